//--- rtl/stt_pkg.sv
// Constants, types and helpers for the sense and trim register bank
//
// Contract
// - Control bit 7 switches shunt amplifier on
// - Control bit 3 disables charge compensation
// - Gain code selects 7 to 36 gain
// - Offsets decode from blocking and non-blocking bases
// - Shunt amplifier output feeds converter channel 9
// - Temperature signal feeds converter channel 11
// - Sleep reference measurable on converter channel 14
// - Battery input to converter and interrupt
// - Internal supply signal routable to converter
// - Trim registers retain contents in low power
// - Reset restores trim registers zero and one
// - Locked trim register two survives reset
// - Trim enable bits gate their trim values
// - Locked analog trim ignores writes until power-down
`default_nettype none
package stt_pkg;

	// Word indices; byte address is four times the index
	localparam logic [9:0] BASE_BLK = 10'h200;
	localparam logic [9:0] BASE_NB = 10'h300;
	localparam logic [7:0] IDX_CSC = 8'h3c;
	localparam logic [7:0] IDX_TRIM0 = 8'hf0;
	localparam logic [7:0] IDX_TRIM1 = 8'hf1;
	localparam logic [7:0] IDX_TRIM2 = 8'hf2;
	localparam logic [7:0] IDX_TRIM3 = 8'hf3;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
	localparam logic [7:0] IDX_IRQ_EN = 8'h41;
	localparam logic [7:0] IDX_IRQ_CLR = 8'h42;

	// Field positions
	localparam int CSC_ON = 7;
	localparam int CSC_COMP_OFF = 3;
	localparam logic [7:0] CSC_MASK = 8'h8f;
	localparam int T2_EN = 4;
	localparam int T2_LOCK = 3;
	localparam logic [7:0] T2_MASK = 8'h1f;

	// Reset values
	localparam logic [7:0] CSC_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h00;

	// Converter channels
	localparam logic [3:0] CH_SHUNT = 4'h9;
	localparam logic [3:0] CH_BATT = 4'ha;
	localparam logic [3:0] CH_TEMP = 4'hb;
	localparam logic [3:0] CH_SUPPLY = 4'hc;
	localparam logic [3:0] CH_SLEEP_REF = 4'he;

	// Interrupt status bits
	localparam int IRQ_N = 2;
	localparam int EV_LOW_BATT = 0;
	localparam int EV_LOCK_REFUSE = 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_ACC = 2'b11
	} stt_apb_e;

	// Switch enables of the converter input multiplexer
	typedef struct packed {
		logic shunt;
		logic battery;
		logic temp;
		logic supply;
		logic sleep_ref;
	} stt_route_s;

	// Effective trim values after enable gating
	typedef struct packed {
		logic bus_slope;
		logic [2:0] dog_clock;
		logic [1:0] spare0;
		logic main_ref_up;
		logic main_ref_dn;
		logic spare1;
		logic [2:0] current_ref;
		logic [2:0] sleep_ref;
		logic [2:0] offset;
		logic [3:0] spare3;
	} stt_trim_s;

	// Amplifier gain for each code
	function automatic logic [5:0] gain_of(input logic [2:0] code);
		case (code)
			3'h0: gain_of = 6'h07;
			3'h1: gain_of = 6'h09;
			3'h2: gain_of = 6'h0a;
			3'h3: gain_of = 6'h0c;
			3'h4: gain_of = 6'h0e;
			3'h5: gain_of = 6'h12;
			3'h6: gain_of = 6'h18;
			default: gain_of = 6'h24;
		endcase
	endfunction

endpackage
`default_nettype wire

//--- rtl/stt_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module stt_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);

	logic s1;
	logic s2;
	logic s3;

	// Shift chain; first stage read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Output follows once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= 1'b0;
		end else if (s2 == s3) begin
			sync_out <= s3;
		end
	end

endmodule
`default_nettype wire

//--- rtl/stt_irq.sv
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ns
`default_nettype none
module stt_irq #(
	parameter int N = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] evt,
	input wire logic en_wr,
	input wire logic clr_wr,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status,
	output logic [N-1:0] enable,
	output logic irq
);

	// Status: a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else begin
			status <= (status & ~(clr_wr ? wdata : '0)) | evt;
		end
	end

	// Enable mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= '0;
		end else if (en_wr) begin
			enable <= wdata;
		end
	end

	// Level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & enable);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	irq_level_a: assert property (|(status & enable) |=> irq)
		else $error("irq low while enabled status set");
	set_wins_a: assert property (|(evt & wdata) && clr_wr |=>
		|(status & $past(evt) & $past(wdata)))
		else $error("event lost under clear");

endmodule
`default_nettype wire

//--- rtl/stt_sense_trim_regs.sv
// Sense control, trim registers and converter routing behind APB
`timescale 1ns/1ns
`default_nettype none
module stt_sense_trim_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic battery_level_input,
	input wire logic conv_sampling,
	input wire logic [3:0] conv_channel,
	output logic shunt_amp_on,
	output logic charge_comp_active,
	output logic [2:0] shunt_gain_code,
	output logic [5:0] shunt_gain,
	output stt_pkg::stt_route_s route,
	output stt_pkg::stt_trim_s trim_out,
	output logic low_battery_irq
);

	////////////////////////////////////////////////////////////////////
	// Address decode

	logic [9:0] idx;
	logic [7:0] off;
	logic in_blk;
	logic in_nb;
	logic mapped;
	logic setup;
	logic do_wr;
	logic wr_lane;

	assign idx = paddr[11:2];
	assign off = idx[7:0];
	// Two windows onto the same registers
	assign in_blk = idx[9:8] == stt_pkg::BASE_BLK[9:8];
	assign in_nb = idx[9:8] == stt_pkg::BASE_NB[9:8];
	assign setup = psel && !penable;
	assign wr_lane = pstrb[0];

	// Known register offsets with an aligned address
	always_comb begin
		mapped = 1'b0;
		if ((in_blk || in_nb) && paddr[1:0] == 2'h0) begin
			case (off)
				stt_pkg::IDX_CSC,
				stt_pkg::IDX_TRIM0,
				stt_pkg::IDX_TRIM1,
				stt_pkg::IDX_TRIM2,
				stt_pkg::IDX_TRIM3,
				stt_pkg::IDX_IRQ_STAT,
				stt_pkg::IDX_IRQ_EN,
				stt_pkg::IDX_IRQ_CLR: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB handshake

	stt_pkg::stt_apb_e state;
	stt_pkg::stt_apb_e next_state;

	// Blocking window adds one wait state, non-blocking none
	always_comb begin
		case (state)
			stt_pkg::ST_IDLE: begin
				if (setup) begin
					next_state = in_blk ? stt_pkg::ST_WAIT : stt_pkg::ST_ACC;
				end else begin
					next_state = stt_pkg::ST_IDLE;
				end
			end
			stt_pkg::ST_WAIT: next_state = stt_pkg::ST_ACC;
			stt_pkg::ST_ACC: next_state = stt_pkg::ST_IDLE;
			default: next_state = stt_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= stt_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Ready and error are raised for the single completing cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= next_state == stt_pkg::ST_ACC;
			pslverr <= (next_state == stt_pkg::ST_ACC) && !mapped;
		end
	end

	// Writes land at the completing edge only
	assign do_wr = psel && penable && pready && pwrite && mapped && wr_lane;

	////////////////////////////////////////////////////////////////////
	// Current-sense control

	logic [7:0] csc;

	// Only bits 7, 3 and 2:0 are storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csc <= stt_pkg::CSC_RST;
		end else if (do_wr && off == stt_pkg::IDX_CSC) begin
			csc <= pwdata[7:0] & stt_pkg::CSC_MASK;
		end
	end

	// Amplifier controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shunt_amp_on <= 1'b0;
			shunt_gain_code <= 3'h0;
			shunt_gain <= 6'h07;
			charge_comp_active <= 1'b0;
		end else begin
			shunt_amp_on <= csc[stt_pkg::CSC_ON];
			shunt_gain_code <= csc[2:0];
			shunt_gain <= stt_pkg::gain_of(csc[2:0]);
			// Compensation runs with each shunt sample while the amplifier is on and bit 3 is clear
			charge_comp_active <= csc[stt_pkg::CSC_ON]
				&& !csc[stt_pkg::CSC_COMP_OFF] && conv_sampling
				&& conv_channel == stt_pkg::CH_SHUNT;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Converter input routing

	// One switch enable per internal source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= '0;
		end else begin
			route.shunt <= shunt_amp_on
				&& conv_channel == stt_pkg::CH_SHUNT;
			route.battery <= conv_channel == stt_pkg::CH_BATT;
			route.temp <= conv_channel == stt_pkg::CH_TEMP;
			route.supply <= conv_channel == stt_pkg::CH_SUPPLY;
			route.sleep_ref <= conv_channel == stt_pkg::CH_SLEEP_REF;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Trim registers

	logic [7:0] trim0;
	logic [7:0] trim1;
	logic [7:0] trim3;
	logic [4:0] trim2;
	logic [2:0] sleep_analog;
	logic t2_locked;
	logic wr_trim2;

	assign t2_locked = trim2[stt_pkg::T2_LOCK];
	assign wr_trim2 = do_wr && off == stt_pkg::IDX_TRIM2;

	// No low-power clear path: contents are held while asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim0 <= stt_pkg::TRIM_RST;
			trim1 <= stt_pkg::TRIM_RST;
			trim3 <= stt_pkg::TRIM_RST;
		end else if (do_wr) begin
			case (off)
				stt_pkg::IDX_TRIM0: trim0 <= pwdata[7:0];
				stt_pkg::IDX_TRIM1: trim1 <= pwdata[7:0];
				stt_pkg::IDX_TRIM3: trim3 <= pwdata[7:0];
				default: trim3 <= trim3;
			endcase
		end
	end

	// Digital copy: cleared at power-on, and by reset only when unlocked
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			trim2 <= 5'h00;
		end else if (!presetn) begin
			if (!t2_locked) begin
				trim2 <= 5'h00;
			end
		end else if (wr_trim2) begin
			if (t2_locked) begin
				trim2[stt_pkg::T2_EN] <= pwdata[stt_pkg::T2_EN];
			end else begin
				trim2 <= pwdata[4:0];
			end
		end
	end

	// Analog copy follows, takes the locking write, then holds
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			sleep_analog <= 3'h0;
		end else if (!t2_locked) begin
			sleep_analog <= wr_trim2 ? pwdata[2:0] : trim2[2:0];
		end
	end

	// Effective trims, each gated by its enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_out <= '0;
		end else begin
			trim_out.bus_slope <= trim0[7] & trim0[6];
			trim_out.dog_clock <= trim0[5] ? trim0[2:0] : 3'h0;
			trim_out.spare0 <= trim0[4:3];
			trim_out.main_ref_up <= trim1[7] & trim1[5];
			trim_out.main_ref_dn <= trim1[7] & trim1[4];
			trim_out.spare1 <= trim1[6];
			trim_out.current_ref <= trim1[3] ? trim1[2:0] : 3'h0;
			trim_out.sleep_ref <= trim2[stt_pkg::T2_EN] ?
				sleep_analog : 3'h0;
			trim_out.offset <= trim3[7] ? trim3[6:4] : 3'h0;
			trim_out.spare3 <= trim3[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Battery alert and interrupts

	logic batt_low;
	logic batt_low_d;
	logic [stt_pkg::IRQ_N-1:0] events;
	logic [stt_pkg::IRQ_N-1:0] irq_status;
	logic [stt_pkg::IRQ_N-1:0] irq_enable;
	logic irq_level;

	stt_sync u_batt_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(battery_level_input),
		.sync_out(batt_low)
	);

	// Edge detector on the filtered level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			batt_low_d <= 1'b0;
		end else begin
			batt_low_d <= batt_low;
		end
	end

	// Event vector: low battery and refused locked write
	always_comb begin
		events = '0;
		events[stt_pkg::EV_LOW_BATT] = batt_low && !batt_low_d;
		events[stt_pkg::EV_LOCK_REFUSE] = wr_trim2 && t2_locked
			&& pwdata[2:0] != trim2[2:0];
	end

	stt_irq #(
		.N(stt_pkg::IRQ_N)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.evt(events),
		.en_wr(do_wr && off == stt_pkg::IDX_IRQ_EN),
		.clr_wr(do_wr && off == stt_pkg::IDX_IRQ_CLR),
		.wdata(pwdata[stt_pkg::IRQ_N-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq_level)
	);

	// Output flop for the interrupt line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_battery_irq <= 1'b0;
		end else begin
			low_battery_irq <= irq_level;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] next_rdata;

	// Narrow registers sit in the low bits, rest reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (off)
			stt_pkg::IDX_CSC: next_rdata[7:0] = csc;
			stt_pkg::IDX_TRIM0: next_rdata[7:0] = trim0;
			stt_pkg::IDX_TRIM1: next_rdata[7:0] = trim1;
			stt_pkg::IDX_TRIM2: next_rdata[4:0] = trim2;
			stt_pkg::IDX_TRIM3: next_rdata[7:0] = trim3;
			stt_pkg::IDX_IRQ_STAT: next_rdata[1:0] = irq_status;
			stt_pkg::IDX_IRQ_EN: next_rdata[1:0] = irq_enable;
			default: next_rdata = 32'h0000_0000;
		endcase
		if (!mapped || pwrite) begin
			next_rdata = 32'h0000_0000;
		end
	end

	// Data captured as the answer is raised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (next_state == stt_pkg::ST_ACC) begin
			prdata <= next_rdata;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence csc_write_s;
		do_wr && off == stt_pkg::IDX_CSC;
	endsequence

	sequence nb_setup_s;
		state == stt_pkg::ST_IDLE && setup && in_nb;
	endsequence

	sequence blk_setup_s;
		state == stt_pkg::ST_IDLE && setup && in_blk;
	endsequence

	amp_enable_a: assert property (csc_write_s ##0 pwdata[7] |->
		##2 shunt_amp_on)
		else $error("amplifier not switched on");
	amp_disable_a: assert property (csc_write_s ##0 !pwdata[7] |->
		##2 !shunt_amp_on)
		else $error("amplifier not switched off");
	gain_top_a: assert property (csc_write_s ##0 pwdata[2:0] == 3'h7
		|-> ##2 shunt_gain == 6'h24)
		else $error("gain code 7 not 36");
	comp_gate_a: assert property (charge_comp_active |->
		$past(conv_sampling) && !$past(csc[stt_pkg::CSC_COMP_OFF]))
		else $error("compensation active while disabled");
	unused_zero_a: assert property (pready && !pwrite
		&& off == stt_pkg::IDX_CSC |-> prdata[6:4] == 3'h0)
		else $error("unused control bits not zero");
	route_shunt_a: assert property (route.shunt |->
		$past(conv_channel) == stt_pkg::CH_SHUNT)
		else $error("shunt routed on wrong channel");
	route_temp_a: assert property (conv_channel == stt_pkg::CH_TEMP
		|=> route.temp && !route.battery)
		else $error("temperature not routed");
	route_ref_a: assert property (conv_channel == stt_pkg::CH_SLEEP_REF
		|=> route.sleep_ref)
		else $error("sleep reference not routed");
	lock_hold_a: assert property (t2_locked |=>
		$stable(sleep_analog))
		else $error("locked analog trim changed");
	lock_write_a: assert property (wr_trim2 && t2_locked |=>
		trim2[3:0] == $past(trim2[3:0]))
		else $error("locked trim accepted write");
	slope_gate_a: assert property (!trim0[7] |=> !trim_out.bus_slope)
		else $error("slope trim applied while disabled");
	nb_ready_a: assert property (nb_setup_s |=> pready)
		else $error("non-blocking answer late");
	blk_ready_a: assert property (blk_setup_s |=> !pready ##1 pready)
		else $error("blocking answer timing wrong");

endmodule
`default_nettype wire

//--- tb/stt_host.sv
// Host-side model: APB master and start-up trim loader
`timescale 1ns/1ns
`default_nettype none
module stt_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Factory trim bytes, the sleep lock bit set in byte two
	logic [7:0] factory_info_flash [4] = '{8'he5, 8'h8b, 8'h1e, 8'hd0};

	// Bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// One transfer: setup, then access until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			// Only the bench watchdog ends a wait that never answers
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			pwdata <= ~d; // Released data does not hold its value
		end
	endtask

	// Byte address is four times base plus index
	function automatic logic [11:0] adr(input logic [9:0] b,
		input logic [7:0] i);
		adr = {b + {2'b00, i}, 2'b00};
	endfunction

	task automatic wr(input logic [9:0] b, input logic [7:0] i,
		input logic [7:0] v);
		logic [31:0] q;
		logic e;
		xfer(1'b1, adr(b, i), {24'h0, v}, q, e);
	endtask

	task automatic rd(input logic [9:0] b, input logic [7:0] i,
		output logic [31:0] q, output logic e);
		xfer(1'b0, adr(b, i), 32'h5a5a5a5a, q, e);
	endtask

	// Start-up copy of whole trim bytes, lock bit masked
	task automatic boot();
		logic [7:0] v;
		for (int k = 0; k < 4; k++) begin
			v = factory_info_flash[k];
			if (k == 2) v[3] = 1'b0;
			wr(stt_pkg::BASE_NB, stt_pkg::IDX_TRIM0 + 8'(k), v);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the sense and trim register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
	err_count++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb;
	logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic battery_level_input, conv_sampling, e;
	logic [3:0] conv_channel;
	logic shunt_amp_on, charge_comp_active, low_battery_irq;
	logic [2:0] shunt_gain_code;
	logic [5:0] shunt_gain;
	stt_pkg::stt_route_s route;
	stt_pkg::stt_trim_s trim_out;
	int err_count = 0;
	int n_compared = 0;
	localparam logic [9:0] B = stt_pkg::BASE_BLK;
	localparam logic [9:0] N = stt_pkg::BASE_NB;
	logic [5:0] gains [8] = '{6'h07, 6'h09, 6'h0a, 6'h0c,
		6'h0e, 6'h12, 6'h18, 6'h24};
	logic [3:0] chans [6] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hd};

	stt_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	stt_sense_trim_regs uut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .battery_level_input(battery_level_input),
		.conv_sampling(conv_sampling), .conv_channel(conv_channel),
		.shunt_amp_on(shunt_amp_on), .charge_comp_active(charge_comp_active),
		.shunt_gain_code(shunt_gain_code), .shunt_gain(shunt_gain),
		.route(route), .trim_out(trim_out), .low_battery_irq(low_battery_irq));

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#300000;
		err_count++;
		stop_test();
	end

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Let registered outputs follow, then look between edges
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask

	// Read one register and compare data and error response
	task automatic rdchk(input logic [9:0] b, input logic [7:0] i,
		input logic [7:0] v);
		host.rd(b, i, q, e);
		`CHK("rdata", {24'h0, v}, q)
		`CHK("pslverr", 1'b0, e)
	endtask

	task automatic do_reset(input logic por);
		presetn <= 1'b0;
		if (por) por_n <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		presetn = 1'b0;
		por_n = 1'b0;
		battery_level_input = 1'b0;
		conv_sampling = 1'b0;
		conv_channel = 4'h0;
		do_reset(1'b1);
		settle();
		`CHK("gain_rst", 6'h07, shunt_gain)
		rdchk(B, stt_pkg::IDX_CSC, 8'h00);
		host.wr(B, stt_pkg::IDX_CSC, 8'hff);
		rdchk(N, stt_pkg::IDX_CSC, 8'h8f);
		for (int c = 0; c < 8; c++) begin
			host.wr(N, stt_pkg::IDX_CSC, {5'b10000, 3'(c)});
			settle();
			`CHK("gain", gains[c], shunt_gain)
			`CHK("gain_code", 3'(c), shunt_gain_code)
			`CHK("amp_on", 1'b1, shunt_amp_on)
		end
		for (int k = 0; k < 6; k++) begin
			@(posedge pclk);
			conv_channel <= chans[k];
			settle();
			`CHK("route", 5'h10 >> k, route)
		end
		@(posedge pclk);
		conv_sampling <= 1'b1;
		conv_channel <= 4'h9;
		host.wr(B, stt_pkg::IDX_CSC, 8'h80);
		settle();
		`CHK("comp", 1'b1, charge_comp_active)
		host.wr(B, stt_pkg::IDX_CSC, 8'h88);
		settle();
		`CHK("comp_off", 1'b0, charge_comp_active)
		`CHK("amp_still_on", 1'b1, shunt_amp_on)
		host.wr(B, stt_pkg::IDX_CSC, 8'h08);
		settle();
		`CHK("amp_off", 1'b0, shunt_amp_on)
		// Low-battery event: raise, clear, then masked
		host.wr(N, stt_pkg::IDX_IRQ_EN, 8'h03);
		battery_level_input <= 1'b1;
		settle();
		settle();
		settle();
		`CHK("irq", 1'b1, low_battery_irq)
		rdchk(N, stt_pkg::IDX_IRQ_STAT, 8'h01);
		battery_level_input <= 1'b0;
		host.wr(N, stt_pkg::IDX_IRQ_CLR, 8'h01);
		settle();
		`CHK("irq_clr", 1'b0, low_battery_irq)
		host.wr(N, stt_pkg::IDX_IRQ_EN, 8'h00);
		battery_level_input <= 1'b1;
		settle();
		settle();
		`CHK("irq_mask", 1'b0, low_battery_irq)
		rdchk(B, stt_pkg::IDX_IRQ_STAT, 8'h01);
		host.wr(N, stt_pkg::IDX_IRQ_CLR, 8'h03);
		// Start-up trim load and enable gating
		host.boot();
		rdchk(B, stt_pkg::IDX_TRIM2, 8'h16);
		settle();
		`CHK("slope", 1'b1, trim_out.bus_slope)
		`CHK("dog", 3'h5, trim_out.dog_clock)
		`CHK("iref", 3'h3, trim_out.current_ref)
		`CHK("sleep", 3'h6, trim_out.sleep_ref)
		`CHK("offs", 3'h5, trim_out.offset)
		host.wr(B, stt_pkg::IDX_TRIM0, 8'h45);
		host.wr(B, stt_pkg::IDX_TRIM1, 8'h30);
		settle();
		`CHK("dog_off", 3'h0, trim_out.dog_clock)
		`CHK("slope_off", 1'b0, trim_out.bus_slope)
		`CHK("ref_off", 2'b00, {trim_out.main_ref_up, trim_out.main_ref_dn})
		// Lock, refused change, then reset and power-down
		host.wr(B, stt_pkg::IDX_TRIM2, 8'h1b);
		host.wr(N, stt_pkg::IDX_TRIM2, 8'h14);
		rdchk(B, stt_pkg::IDX_TRIM2, 8'h1b);
		rdchk(N, stt_pkg::IDX_IRQ_STAT, 8'h02);
		settle();
		`CHK("locked", 3'h3, trim_out.sleep_ref)
		@(posedge pclk);
		do_reset(1'b0);
		rdchk(N, stt_pkg::IDX_TRIM0, 8'h00);
		rdchk(N, stt_pkg::IDX_TRIM1, 8'h00);
		rdchk(N, stt_pkg::IDX_TRIM2, 8'h1b);
		rdchk(N, stt_pkg::IDX_CSC, 8'h00);
		do_reset(1'b1);
		rdchk(N, stt_pkg::IDX_TRIM2, 8'h00);
		// Unmapped and unaligned accesses
		host.rd(N, 8'h50, q, e);
		`CHK("unmap_err", 1'b1, e)
		`CHK("unmap_q", 32'h0, q)
		host.xfer(1'b0, 12'hcf1, 32'h0, q, e);
		`CHK("unalign", 1'b1, e)
		stop_test();
	end
endmodule
`default_nettype wire
